// [design/dcs_top.sv]
// Register file and pin control for the dual comparator block
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcs_top (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic debug_mode,
	input wire logic idle_mode,
	input wire logic [1:0] raw_cmp,
	input wire logic [1:0] pin_direction,
	input wire logic [dcs_pkg::PORT_W-1:0] port_pins,
	output logic [1:0] result_pin,
	output logic [1:0] result_pin_oe,
	output dcs_pkg::dcs_ana_t ana1,
	output dcs_pkg::dcs_ana_t ana2,
	output logic irq
);
	typedef struct packed {
		logic [1:0] rst_sync;
		logic freeze_in_debug;
		logic stop_when_idle;
		dcs_pkg::dcs_con_t con1;
		dcs_pkg::dcs_con_t con2;
		logic [1:0] pin_oe;
		logic [1:0] ev_stat;
		logic [1:0] ev_en;
		logic [dcs_pkg::PORT_W-1:0] ansel;
		logic [31:0] rdata;
		logic irq;
		dcs_pkg::dcs_ana_t ana1;
		dcs_pkg::dcs_ana_t ana2;
	} dcs_top_st_t;

	dcs_top_st_t st_q;
	dcs_top_st_t st_d;
	logic rst_n;
	logic run;
	logic [1:0] res;
	logic [1:0] evp;

	assign rst_n = st_q.rst_sync[1];

	// Freeze in debug and stop in idle both gate channel operation
	assign run = !(st_q.freeze_in_debug && debug_mode)
		&& !(st_q.stop_when_idle && idle_mode);

	function automatic dcs_pkg::dcs_con_t con_wr(input logic [31:0] w);
		dcs_pkg::dcs_con_t c;
		c.on = w[dcs_pkg::CON_ON_BIT];
		c.oe = w[dcs_pkg::CON_OE_BIT];
		c.pol = w[dcs_pkg::CON_POL_BIT];
		c.ev = w[dcs_pkg::CON_EV_LSB +: 2];
		c.ref_sel = w[dcs_pkg::CON_REF_BIT];
		c.ch = w[dcs_pkg::CON_CH_LSB +: 2];
		return c;
	endfunction

	function automatic logic [31:0] con_rd(input dcs_pkg::dcs_con_t c,
		input logic r);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[dcs_pkg::CON_ON_BIT] = c.on;
		v[dcs_pkg::CON_OE_BIT] = c.oe;
		v[dcs_pkg::CON_POL_BIT] = c.pol;
		v[dcs_pkg::CON_RES_BIT] = r;
		v[dcs_pkg::CON_EV_LSB +: 2] = c.ev;
		v[dcs_pkg::CON_REF_BIT] = c.ref_sel;
		v[dcs_pkg::CON_CH_LSB +: 2] = c.ch;
		return v;
	endfunction

	function automatic dcs_pkg::dcs_ana_t ana_map(input dcs_pkg::dcs_con_t c,
		input logic run_i);
		dcs_pkg::dcs_ana_t a;
		a.noninv_ref = c.ref_sel;
		a.inv_sel = c.ch;
		a.enable = c.on && run_i;
		return a;
	endfunction

	dcs_chan u_chan1 (
		.clock(clock),
		.rst_n(rst_n),
		.con(st_q.con1),
		.run(run),
		.raw_cmp(raw_cmp[0]),
		.result(res[0]),
		.event_pulse(evp[0])
	);

	dcs_chan u_chan2 (
		.clock(clock),
		.rst_n(rst_n),
		.con(st_q.con2),
		.run(run),
		.raw_cmp(raw_cmp[1]),
		.result(res[1]),
		.event_pulse(evp[1])
	);

	always_comb begin
		st_d = st_q;
		st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
		st_d.rdata = 32'h0000_0000;
		// Freeze bit only leaves its reset state while in debug
		if (!debug_mode) begin
			st_d.freeze_in_debug = 1'b0;
		end
		if (wr) begin
			case (addr)
				dcs_pkg::ADDR_STAT: begin
					if (debug_mode) begin
						st_d.freeze_in_debug = wdata[dcs_pkg::STAT_FRZ_BIT];
					end
					st_d.stop_when_idle = wdata[dcs_pkg::STAT_STOP_WHEN_IDLE_BIT];
				end
				dcs_pkg::ADDR_CON1: begin
					// Result bit not stored; other fields independent
					st_d.con1 = con_wr(wdata);
				end
				dcs_pkg::ADDR_CON2: begin
					st_d.con2 = con_wr(wdata);
				end
				dcs_pkg::ADDR_IRQ_EN: begin
					st_d.ev_en = wdata[1:0];
				end
				dcs_pkg::ADDR_ANSEL: begin
					st_d.ansel = wdata[dcs_pkg::PORT_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// Set wins over a clear in the same cycle
		if (wr && addr == dcs_pkg::ADDR_IRQ_CLR) begin
			st_d.ev_stat = st_q.ev_stat & ~wdata[1:0];
		end
		st_d.ev_stat = st_d.ev_stat | evp;
		if (rd) begin
			// Result bits are sampled at the read and shown in rdata for one cycle only
			case (addr)
				dcs_pkg::ADDR_STAT: begin
					st_d.rdata[dcs_pkg::STAT_FRZ_BIT] = st_q.freeze_in_debug && debug_mode;
					st_d.rdata[dcs_pkg::STAT_STOP_WHEN_IDLE_BIT] = st_q.stop_when_idle;
					st_d.rdata[dcs_pkg::STAT_R2_BIT] = res[1];
					st_d.rdata[dcs_pkg::STAT_R1_BIT] = res[0];
				end
				dcs_pkg::ADDR_CON1: begin
					st_d.rdata = con_rd(st_q.con1, res[0]);
				end
				dcs_pkg::ADDR_CON2: begin
					st_d.rdata = con_rd(st_q.con2, res[1]);
				end
				dcs_pkg::ADDR_IRQ_STAT: begin
					st_d.rdata[1:0] = st_q.ev_stat;
				end
				dcs_pkg::ADDR_IRQ_EN: begin
					st_d.rdata[1:0] = st_q.ev_en;
				end
				dcs_pkg::ADDR_PORT: begin
					// Analog-configured pins read zero
					st_d.rdata[dcs_pkg::PORT_W-1:0] = port_pins & ~st_q.ansel;
				end
				dcs_pkg::ADDR_ANSEL: begin
					st_d.rdata[dcs_pkg::PORT_W-1:0] = st_q.ansel;
				end
				default: begin
				end
			endcase
		end
		st_d.irq = |(st_d.ev_stat & st_d.ev_en);
		st_d.ana1 = ana_map(st_d.con1, run);
		st_d.ana2 = ana_map(st_d.con2, run);
		// Pin drive follows direction one cycle later
		st_d.pin_oe[0] = st_d.con1.oe && st_d.con1.on && pin_direction[0];
		st_d.pin_oe[1] = st_d.con2.oe && st_d.con2.on && pin_direction[1];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
			st_q.con1.ev <= dcs_pkg::CON_EV_RESET;
			st_q.con1.ch <= dcs_pkg::CON_CH_RESET;
			st_q.con2.ev <= dcs_pkg::CON_EV_RESET;
			st_q.con2.ch <= dcs_pkg::CON_CH_RESET;
			st_q.ansel <= dcs_pkg::ANSEL_RESET;
			st_q.ana1.inv_sel <= dcs_pkg::CON_CH_RESET;
			st_q.ana2.inv_sel <= dcs_pkg::CON_CH_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Raw analog output drives the pin with no flop by design; it is the
	// documented unsynchronised path, so glitches reach the pin
	assign result_pin[0] = raw_cmp[0] ^ st_q.con1.pol;
	assign result_pin[1] = raw_cmp[1] ^ st_q.con2.pol;
	assign result_pin_oe = st_q.pin_oe;
	assign rdata = st_q.rdata;
	assign irq = st_q.irq;
	assign ana1 = st_q.ana1;
	assign ana2 = st_q.ana2;
endmodule
`default_nettype wire

// [shared/dcs_pkg.sv]
// Package for the dual comparator status and control block
// What this block does
// - Freeze bit set halts comparator logic while the processor is in debug.
// - Freeze bit writable only in debug; reads zero outside debug.
// - Stop-when-idle set disables both comparators during idle mode.
// - Status bit 1 is second result, bit 0 first result, read-only.
// - Non-inverting input: pin or ladder; inverting: three pins or fixed band.
// - Per-comparator event control: level reached or any change.
// - Result is high when non-inverting exceeds inverting, low when below.
// - Control register result bit is read-only; writes ignored.
// - Result bit stays valid while routed to the output pin.
// - Pin gets the raw unsynchronised result only when direction is output.
// - Reading the result bit returns the value sampled at the read.
// - Inversion bit set inverts the result; clear passes it unchanged.
// - Port data reads zero for every pin configured as analog input.
// - Edge select: 00 none, 01 rise, 10 fall, 11 both; after inversion.
// - Enable bit changes alter no other stored bit of the control register; clearing it makes the result bit read zero.
package dcs_pkg;
	localparam logic [3:0] ADDR_STAT = 4'h0;
	localparam logic [3:0] ADDR_CON1 = 4'h1;
	localparam logic [3:0] ADDR_CON2 = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
	localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
	localparam logic [3:0] ADDR_PORT = 4'h6;
	localparam logic [3:0] ADDR_ANSEL = 4'h7;
	localparam int STAT_FRZ_BIT = 14;
	localparam int STAT_STOP_WHEN_IDLE_BIT = 13;
	localparam int STAT_R2_BIT = 1;
	localparam int STAT_R1_BIT = 0;
	localparam int CON_ON_BIT = 15;
	localparam int CON_OE_BIT = 14;
	localparam int CON_POL_BIT = 13;
	localparam int CON_RES_BIT = 8;
	localparam int CON_EV_LSB = 6;
	localparam int CON_REF_BIT = 4;
	localparam int CON_CH_LSB = 0;
	localparam logic [1:0] CON_EV_RESET = 2'h3;
	localparam logic [1:0] CON_CH_RESET = 2'h3;
	localparam logic [1:0] EV_NONE = 2'h0;
	localparam logic [1:0] EV_RISE = 2'h1;
	localparam logic [1:0] EV_FALL = 2'h2;
	localparam logic [1:0] EV_BOTH = 2'h3;
	localparam logic [1:0] CH_PIN_NEG = 2'h0;
	localparam logic [1:0] CH_PIN_OWN = 2'h1;
	localparam logic [1:0] CH_PIN_OTHER = 2'h2;
	localparam logic [1:0] CH_BAND = 2'h3;
	localparam int PORT_W = 8;
	localparam logic [PORT_W-1:0] ANSEL_RESET = 8'hFF;

	typedef struct packed {
		logic on;
		logic oe;
		logic pol;
		logic [1:0] ev;
		logic ref_sel;
		logic [1:0] ch;
	} dcs_con_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dcs_bus_t;

	typedef struct packed {
		logic noninv_ref;
		logic [1:0] inv_sel;
		logic enable;
	} dcs_ana_t;
endpackage

// [design/dcs_chan.sv]
// One comparator channel: gating, polarity, sampling and event detection
`timescale 1ns/1ps
`default_nettype none
module dcs_chan (
	input wire logic clock,
	input wire logic rst_n,
	input wire dcs_pkg::dcs_con_t con,
	input wire logic run,
	input wire logic raw_cmp,
	output logic result,
	output logic event_pulse
);
	typedef struct packed {
		logic sync1;
		logic result;
		logic prev;
		logic primed;
		logic event_pulse;
	} dcs_chan_st_t;

	dcs_chan_st_t st_q;
	dcs_chan_st_t st_d;
	logic pol_res;

	always_comb begin
		st_d = st_q;
		st_d.event_pulse = 1'b0;
		st_d.sync1 = raw_cmp;
		// Polarity applied before the edge detector
		pol_res = st_q.sync1 ^ con.pol;
		if (run && con.on) begin
			st_d.result = pol_res;
			st_d.prev = pol_res;
			st_d.primed = 1'b1;
			// First sample after enable is not an edge, avoids false events
			if (st_q.primed) begin
				case (con.ev)
					dcs_pkg::EV_RISE: begin
						st_d.event_pulse = pol_res & ~st_q.prev;
					end
					dcs_pkg::EV_FALL: begin
						st_d.event_pulse = ~pol_res & st_q.prev;
					end
					dcs_pkg::EV_BOTH: begin
						st_d.event_pulse = pol_res ^ st_q.prev;
					end
					default: begin
						st_d.event_pulse = 1'b0;
					end
				endcase
			end
		end else if (!con.on) begin
			st_d.primed = 1'b0;
			st_d.result = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign result = st_q.result;
	assign event_pulse = st_q.event_pulse;
endmodule
`default_nettype wire

// [testbench/dcs_checker.sv]
// Port assertions for the dual comparator block
`timescale 1ns/1ps
`default_nettype none
module dcs_checker (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [31:0] rdata,
	input wire logic debug_mode,
	input wire logic [1:0] raw_cmp,
	input wire logic [1:0] pin_direction,
	input wire logic [dcs_pkg::PORT_W-1:0] port_pins,
	input wire logic [1:0] result_pin,
	input wire logic [1:0] result_pin_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_quiet;
		!$past(rd) |-> rdata == 32'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("rdata not idle");
	property p_oe;
		(result_pin_oe & ~$past(pin_direction)) == 2'h0;
	endproperty
	a_oe: assert property (p_oe) else $error("pin driven as input");
	// Pin follows the raw input at once unless a write changed polarity
	property p_raw;
		!$past(wr) |-> $stable(result_pin ^ raw_cmp);
	endproperty
	a_raw: assert property (p_raw) else $error("pin not raw");
	property p_frz;
		$past(rd) && $past(addr) == 4'h0 && !$past(debug_mode)
			&& !$past(debug_mode, 2) |-> !rdata[14];
	endproperty
	a_frz: assert property (p_frz) else $error("freeze reads one");
	property p_stat;
		$past(rd) && $past(addr) == 4'h0 |-> (rdata & 32'hFFFF9FFC) == 32'h0;
	endproperty
	a_stat: assert property (p_stat) else $error("status spare set");
	property p_con;
		$past(rd) && $past(addr) inside {4'h1, 4'h2}
			|-> (rdata & 32'hFFFF1E2C) == 32'h0;
	endproperty
	a_con: assert property (p_con) else $error("control spare set");
	property p_port;
		$past(rd) && $past(addr) == 4'h6 |-> (rdata & ~32'($past(port_pins))) == 32'h0;
	endproperty
	a_port: assert property (p_port) else $error("port bit invented");
	property p_hole;
		$past(rd) && $past(addr) > 4'h7 |-> rdata == 32'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped read");
endmodule
`default_nettype wire

// [testbench/dcs_top_bench.sv]
// Self-checking bench for the dual comparator block
`timescale 1ns/1ps
`default_nettype none
module dcs_top_bench;
	logic clock = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, pend = 1'b0;
	logic debug_mode = 1'b0, idle_mode = 1'b0, irq, r1, r2;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [1:0] raw_cmp = 2'h0, pin_direction = 2'h0, result_pin, result_pin_oe;
	logic [7:0] port_pins = 8'h0;
	logic [63:0] q[$];
	logic [63:0] v;
	dcs_pkg::dcs_ana_t ana1, ana2;
	int bad_count = 0, n_checks = 0, seed = 32'h13ED;
	always #12.5 clock = ~clock;
	dcs_top dut_u (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata,
		.debug_mode, .idle_mode, .raw_cmp, .pin_direction, .port_pins,
		.result_pin, .result_pin_oe, .ana1, .ana2, .irq);
	task automatic chk(input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic wrt(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// Mask in the top half: bits the rules leave open are not compared
	task automatic rdx(input logic [3:0] a, input logic [31:0] e, m);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		q.push_back({m, e});
		@(posedge clock);
		rd <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clock) begin
		if (pend) begin
			v = q.pop_front();
			chk(rdata & v[63:32], v[31:0] & v[63:32]);
		end
		pend <= rd;
	end
	initial begin
		#100us;
		bad_count++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		idle(3);
		rdx(4'h1, 32'h00C3, '1);
		rdx(4'h0, 32'h0, '1);
		rdx(4'h7, 32'hFF, '1);
		rdx(4'h9, 32'h0, '1);
		for (int c = 0; c < 8; c++) begin
			wrt(4'h1, {16'h0, 1'b1, 10'h0, c[2], 2'h0, c[1:0]});
			idle(2);
			chk(32'(ana1), 32'({c[2], c[1:0], 1'b1}));
		end
		for (int i = 0; i < 8; i++) begin
			r1 = i[0] ^ i[2];
			r2 = ~i[0] ^ i[2];
			raw_cmp <= {~i[0], i[0]};
			pin_direction <= {i[1], i[1]};
			wrt(4'h1, {16'h0, 1'b1, 1'b1, i[2], 4'h0, 1'b1, 8'h0});
			wrt(4'h2, {16'h0, 1'b1, 1'b1, i[2], 4'h0, 1'b1, 8'h0});
			idle(4);
			rdx(4'h0, {30'h0, r2, r1}, 32'h3);
			rdx(4'h1, {23'h0, r1, 8'h0}, 32'h100);
			chk(32'({result_pin, result_pin_oe}), 32'({r2, r1, i[1], i[1]}));
		end
		// Events are masked across each reconfiguration to avoid false flags
		for (int e = 0; e < 8; e++) begin
			raw_cmp <= 2'h0;
			wrt(4'h4, 32'h0);
			wrt(4'h1, {16'h0, 1'b1, 1'b0, e[2], 5'h0, e[1:0], 6'h0});
			idle(6);
			wrt(4'h5, 32'h3);
			wrt(4'h4, 32'h1);
			raw_cmp <= 2'h1;
			idle(8);
			chk(32'(irq), 32'(e[2] ? e[1] : e[0]));
			wrt(4'h5, 32'h3);
			raw_cmp <= 2'h0;
			idle(8);
			chk(32'(irq), 32'(e[2] ? e[0] : e[1]));
		end
		wrt(4'h4, 32'h0);
		raw_cmp <= 2'h1;
		idle(8);
		chk(32'(irq), 32'h0);
		rdx(4'h3, 32'h1, 32'h1);
		wrt(4'h4, 32'h1);
		idle(3);
		chk(32'(irq), 32'h1);
		wrt(4'h5, 32'h3);
		idle(3);
		chk(32'(irq), 32'h0);
		wrt(4'h0, 32'h2000);
		idle_mode <= 1'b1;
		idle(3);
		chk(32'({ana1.enable, ana2.enable}), 32'h0);
		raw_cmp <= 2'h0;
		idle(4);
		rdx(4'h0, 32'h2000, 32'h2001);
		idle_mode <= 1'b0;
		idle(4);
		chk(32'({ana1.enable, ana2.enable}), 32'h3);
		rdx(4'h0, 32'h2001, 32'h2001);
		wrt(4'h0, 32'h4000);
		rdx(4'h0, 32'h0, 32'h4000);
		debug_mode <= 1'b1;
		wrt(4'h0, 32'h4000);
		raw_cmp <= 2'h1;
		idle(4);
		chk(32'({ana1.enable, ana2.enable}), 32'h0);
		rdx(4'h0, 32'h4001, 32'h4001);
		debug_mode <= 1'b0;
		idle(4);
		rdx(4'h0, 32'h0, 32'h4001);
		wrt(4'h2, 32'h60D1);
		idle(2);
		chk(32'(ana2), 32'hA);
		rdx(4'h2, 32'h60D1, 32'hFFFFFEFF);
		wrt(4'h2, 32'hE0D1);
		idle(2);
		chk(32'(ana2), 32'hB);
		rdx(4'h2, 32'hE0D1, 32'hFFFFFEFF);
		repeat (4) begin
			rv = $random(seed);
			port_pins <= rv[7:0];
			wrt(4'h7, {24'h0, rv[15:8]});
			rdx(4'h6, {24'h0, rv[7:0] & ~rv[15:8]}, '1);
		end
		idle(4);
		wrap_up;
	end
endmodule
bind dcs_top dcs_checker chk_u (.clock, .resetn, .addr, .rd, .wr, .rdata,
	.debug_mode, .raw_cmp, .pin_direction, .port_pins, .result_pin,
	.result_pin_oe);
`default_nettype wire
